// >>> verilog/prpi_consts.vh
// Purpose: constants for the parallel RGB pixel input port
// Assumes: included by bare name; definitions only
// Notes: widths and mapping codes shared by the design
`ifndef PRPI_CONSTS_VH
`define PRPI_CONSTS_VH
// Pixel word and colour channel widths
`define PRPI_PIX_W 24
`define PRPI_CHAN_W 8
`define PRPI_BUS_W 10
// Upper bits of a 10-bit colour bus carry the 8-bit colour
`define PRPI_BUS_MSB 9
`define PRPI_BUS_LSB 2
// Swap select codes for one logical channel
`define PRPI_SEL_A 2'h0
`define PRPI_SEL_B 2'h1
`define PRPI_SEL_C 2'h2
// Swap field positions: red, green, blue source selects
`define PRPI_SWAP_R 1:0
`define PRPI_SWAP_G 3:2
`define PRPI_SWAP_B 5:4
// Reset value of the swap is identity mapping
`define PRPI_SWAP_RST 6'h24
// Buffered word: frame mark, line mark, pixel
`define PRPI_WORD_W 26
`define PRPI_SOF_BIT 25
`define PRPI_SOL_BIT 24
`endif

// >>> verilog/prpi_top.v
// Purpose: capture two parallel RGB pixel ports into buffered streams
// Assumes: pixel clocks far slower than i_clk_sys; syncs active high
// Notes: each port is sampled on edges of its own pixel clock
// Contract
// - Each port times its data, syncs and valid on its own pixel clock.
// - Port one accepts 24-bit pixel words; port two accepts 30-bit words, keeping the upper 8 bits of each channel.
// - A pixel word is three 8-bit channels: red, green and blue.
// - The A, B and C channels of both ports can be remapped to colours.
// - An optional third pixel clock may time a port instead.
`timescale 1ns/1ps
`include "prpi_consts.vh"

module prpi_port
(
   input wire i_clk_sys,
   input wire i_rst_n,
   input wire i_pix_clk,
   input wire i_third_clk,
   input wire i_use_third,
   input wire [3*`PRPI_BUS_W-1:0] i_colour_data,
   input wire i_frame_sync,
   input wire i_line_sync,
   input wire i_data_valid,
   input wire [5:0] i_swap,
   input wire i_ready,
   output reg [`PRPI_PIX_W-1:0] o_pixel,
   output reg o_valid,
   output reg o_frame_start,
   output reg o_line_start,
   output reg o_overrun
);

   // Pick one of the A, B or C channels, upper 8 bits only
   function [`PRPI_CHAN_W-1:0] pick_chan;
      input [3*`PRPI_BUS_W-1:0] bus;
      input [1:0] sel;
      begin
         case (sel)
            `PRPI_SEL_A: pick_chan = bus[`PRPI_BUS_MSB:`PRPI_BUS_LSB];
            `PRPI_SEL_B: pick_chan =
               bus[`PRPI_BUS_W+`PRPI_BUS_MSB:`PRPI_BUS_W+`PRPI_BUS_LSB];
            `PRPI_SEL_C: pick_chan =
               bus[2*`PRPI_BUS_W+`PRPI_BUS_MSB:2*`PRPI_BUS_W+`PRPI_BUS_LSB];
            default: pick_chan = bus[`PRPI_BUS_MSB:`PRPI_BUS_LSB];
         endcase
      end
   endfunction

   reg [1:0] clk_sync_q;
   reg [1:0] clk3_sync_q;
   reg clk_last_q;
   reg [3*`PRPI_BUS_W-1:0] data_s1_q;
   reg [3*`PRPI_BUS_W-1:0] data_s2_q;
   reg [2:0] ctl_s1_q;
   reg [2:0] ctl_s2_q;
   reg vs_last_q;
   reg hs_last_q;
   reg sof_pend_q;
   reg sol_pend_q;
   reg [`PRPI_WORD_W-1:0] skid_q;
   reg skid_vld_q;
   wire sel_clk;
   wire pix_edge;
   wire take;
   wire in_ready;
   wire vs_rise;
   wire hs_rise;
   wire [`PRPI_PIX_W-1:0] pix_map;
   wire [`PRPI_WORD_W-1:0] word_in;
   wire out_free;

   // Two-flop synchronisers for clocks, data and controls
   always @(posedge i_clk_sys or negedge i_rst_n)
   begin
      if (!i_rst_n)
      begin
         clk_sync_q <= 2'h0;
         clk3_sync_q <= 2'h0;
         data_s1_q <= {3*`PRPI_BUS_W{1'b0}};
         data_s2_q <= {3*`PRPI_BUS_W{1'b0}};
         ctl_s1_q <= 3'h0;
         ctl_s2_q <= 3'h0;
      end
      else
      begin
         clk_sync_q <= {clk_sync_q[0], i_pix_clk};
         clk3_sync_q <= {clk3_sync_q[0], i_third_clk};
         data_s1_q <= i_colour_data;
         data_s2_q <= data_s1_q;
         ctl_s1_q <= {i_frame_sync, i_line_sync, i_data_valid};
         ctl_s2_q <= ctl_s1_q;
      end
   end

   // Timing reference: own pixel clock or the optional third one
   assign sel_clk = i_use_third ? clk3_sync_q[1] : clk_sync_q[1];
   assign pix_edge = sel_clk & ~clk_last_q;
   assign take = pix_edge & ctl_s2_q[0];
   assign vs_rise = pix_edge & ctl_s2_q[2] & ~vs_last_q;
   assign hs_rise = pix_edge & ctl_s2_q[1] & ~hs_last_q;

   // Channel remap to red, green, blue; 8 bits each
   assign pix_map = {pick_chan(data_s2_q, i_swap[`PRPI_SWAP_R]),
                     pick_chan(data_s2_q, i_swap[`PRPI_SWAP_G]),
                     pick_chan(data_s2_q, i_swap[`PRPI_SWAP_B])};
   assign word_in = {sof_pend_q | vs_rise, sol_pend_q | hs_rise,
                     pix_map};
   assign in_ready = ~skid_vld_q;
   assign out_free = ~o_valid | i_ready;

   // Edge history and pending frame and line marks
   always @(posedge i_clk_sys or negedge i_rst_n)
   begin
      if (!i_rst_n)
      begin
         clk_last_q <= 1'b0;
         vs_last_q <= 1'b0;
         hs_last_q <= 1'b0;
         sof_pend_q <= 1'b0;
         sol_pend_q <= 1'b0;
      end
      else
      begin
         clk_last_q <= sel_clk;
         if (pix_edge)
         begin
            vs_last_q <= ctl_s2_q[2];
            hs_last_q <= ctl_s2_q[1];
         end
         // Mark waits for the next stored pixel; a dropped one keeps it
         if (take & (in_ready | out_free))
         begin
            sof_pend_q <= 1'b0;
            sol_pend_q <= 1'b0;
         end
         else
         begin
            sof_pend_q <= sof_pend_q | vs_rise;
            sol_pend_q <= sol_pend_q | hs_rise;
         end
      end
   end

   // Two-entry buffer: output stage plus skid stage
   always @(posedge i_clk_sys or negedge i_rst_n)
   begin
      if (!i_rst_n)
      begin
         o_pixel <= {`PRPI_PIX_W{1'b0}};
         o_frame_start <= 1'b0;
         o_line_start <= 1'b0;
         o_valid <= 1'b0;
         skid_q <= {`PRPI_WORD_W{1'b0}};
         skid_vld_q <= 1'b0;
         o_overrun <= 1'b0;
      end
      else
      begin
         if (out_free)
         begin
            if (skid_vld_q)
            begin
               o_pixel <= skid_q[`PRPI_PIX_W-1:0];
               o_frame_start <= skid_q[`PRPI_SOF_BIT];
               o_line_start <= skid_q[`PRPI_SOL_BIT];
               o_valid <= 1'b1;
               skid_vld_q <= take;
               skid_q <= word_in;
            end
            else
            begin
               o_pixel <= word_in[`PRPI_PIX_W-1:0];
               o_frame_start <= word_in[`PRPI_SOF_BIT] & take;
               o_line_start <= word_in[`PRPI_SOL_BIT] & take;
               o_valid <= take;
            end
         end
         else if (take & in_ready)
         begin
            skid_q <= word_in;
            skid_vld_q <= 1'b1;
         end
         // Sticky: a word arrived with both stages full
         if (take & ~in_ready & ~out_free)
            o_overrun <= 1'b1;
      end
   end

endmodule // prpi_port

module prpi_top
(
   input wire i_clk_sys,
   input wire i_rst_n,
   input wire i_port_one_pixel_clock,
   input wire i_port_two_pixel_clock,
   input wire i_optional_third_pixel_clock,
   input wire i_port_one_use_third_clock,
   input wire i_port_two_use_third_clock,
   input wire [3*`PRPI_CHAN_W-1:0] i_port_one_colour_data,
   input wire [3*`PRPI_BUS_W-1:0] i_port_two_colour_data,
   input wire i_port_one_frame_sync,
   input wire i_port_one_line_sync,
   input wire i_port_one_data_valid,
   input wire i_port_two_frame_sync,
   input wire i_port_two_line_sync,
   input wire i_port_two_data_valid,
   input wire [5:0] i_port_one_swap,
   input wire [5:0] i_port_two_swap,
   input wire i_port_one_ready,
   input wire i_port_two_ready,
   output wire [`PRPI_PIX_W-1:0] o_port_one_pixel,
   output wire o_port_one_valid,
   output wire o_port_one_frame_start,
   output wire o_port_one_line_start,
   output wire o_port_one_overrun,
   output wire [`PRPI_PIX_W-1:0] o_port_two_pixel,
   output wire o_port_two_valid,
   output wire o_port_two_frame_start,
   output wire o_port_two_line_start,
   output wire o_port_two_overrun
);

   reg [1:0] rst_sync_q;
   wire rst_n;
   wire [3*`PRPI_BUS_W-1:0] p1_bus;

   // Reset release through two flops
   always @(posedge i_clk_sys or negedge i_rst_n)
   begin
      if (!i_rst_n)
         rst_sync_q <= 2'h0;
      else
         rst_sync_q <= {rst_sync_q[0], 1'b1};
   end
   assign rst_n = rst_sync_q[1];

   // Port one has only the upper 8 bits of each channel
   assign p1_bus = {i_port_one_colour_data[23:16], 2'h0,
                    i_port_one_colour_data[15:8], 2'h0,
                    i_port_one_colour_data[7:0], 2'h0};

   prpi_port u_port_one
   (
      .i_clk_sys(i_clk_sys),
      .i_rst_n(rst_n),
      .i_pix_clk(i_port_one_pixel_clock),
      .i_third_clk(i_optional_third_pixel_clock),
      .i_use_third(i_port_one_use_third_clock),
      .i_colour_data(p1_bus),
      .i_frame_sync(i_port_one_frame_sync),
      .i_line_sync(i_port_one_line_sync),
      .i_data_valid(i_port_one_data_valid),
      .i_swap(i_port_one_swap),
      .i_ready(i_port_one_ready),
      .o_pixel(o_port_one_pixel),
      .o_valid(o_port_one_valid),
      .o_frame_start(o_port_one_frame_start),
      .o_line_start(o_port_one_line_start),
      .o_overrun(o_port_one_overrun)
   );

   prpi_port u_port_two
   (
      .i_clk_sys(i_clk_sys),
      .i_rst_n(rst_n),
      .i_pix_clk(i_port_two_pixel_clock),
      .i_third_clk(i_optional_third_pixel_clock),
      .i_use_third(i_port_two_use_third_clock),
      .i_colour_data(i_port_two_colour_data),
      .i_frame_sync(i_port_two_frame_sync),
      .i_line_sync(i_port_two_line_sync),
      .i_data_valid(i_port_two_data_valid),
      .i_swap(i_port_two_swap),
      .i_ready(i_port_two_ready),
      .o_pixel(o_port_two_pixel),
      .o_valid(o_port_two_valid),
      .o_frame_start(o_port_two_frame_start),
      .o_line_start(o_port_two_line_start),
      .o_overrun(o_port_two_overrun)
   );

endmodule // prpi_top

// >>> tb/prpi_chk.sv
// Purpose: port checks for prpi_top
// Assumes: registered outputs, 2-flop pin sync
// Notes: bound to prpi_top below
`timescale 1ns/1ps
`include "prpi_consts.vh"
module prpi_chk
(
   input logic i_clk_sys,
   input logic i_rst_n,
   input logic i_port_one_pixel_clock,
   input logic i_port_one_use_third_clock,
   input logic i_port_one_data_valid,
   input logic i_port_one_ready,
   input logic [`PRPI_PIX_W-1:0] o_port_one_pixel,
   input logic o_port_one_valid,
   input logic o_port_one_frame_start,
   input logic o_port_one_overrun,
   input logic i_optional_third_pixel_clock,
   input logic i_port_two_use_third_clock,
   input logic o_port_two_valid,
   input logic o_port_two_line_start
);
   // All checks on the system clock
   default clocking @(posedge i_clk_sys); endclocking
   default disable iff (!i_rst_n);
   // New word follows an edge of the selected pixel clock
   property p_own_clk;
      $rose(o_port_one_valid) && !i_port_one_use_third_clock |->
         $past(i_port_one_pixel_clock, 3) || $past(i_port_one_pixel_clock, 4);
   endproperty
   a_own_clk: assert property (p_own_clk)
      else $error("port one word without pixel clock edge");
   property p_third_clk;
      $rose(o_port_two_valid) && i_port_two_use_third_clock |->
         $past(i_optional_third_pixel_clock, 3) ||
         $past(i_optional_third_pixel_clock, 4);
   endproperty
   a_third_clk: assert property (p_third_clk)
      else $error("port two word without third clock edge");
   // Capture only with valid high at the edge
   property p_dv;
      $rose(o_port_one_valid) |-> $past(i_port_one_data_valid, 3);
   endproperty
   a_dv: assert property (p_dv)
      else $error("word captured with valid low");
   // Stalled word stands unchanged
   property p_hold;
      o_port_one_valid && !i_port_one_ready |=>
         o_port_one_valid && $stable(o_port_one_pixel);
   endproperty
   a_hold: assert property (p_hold)
      else $error("stalled word changed");
   // Marks only ride on a word
   property p_fmark;
      o_port_one_frame_start |-> o_port_one_valid;
   endproperty
   a_fmark: assert property (p_fmark)
      else $error("frame mark without word");
   property p_lmark;
      o_port_two_line_start |-> o_port_two_valid;
   endproperty
   a_lmark: assert property (p_lmark)
      else $error("line mark without word");
   // Lost word flag is sticky
   property p_ovr;
      o_port_one_overrun |=> o_port_one_overrun;
   endproperty
   a_ovr: assert property (p_ovr)
      else $error("overrun flag cleared");
endmodule // prpi_chk
bind prpi_top prpi_chk i_chk (.*);

// >>> tb/prpi_src.sv
// Purpose: video source model for one pixel port
// Assumes: 48 ns pixel clock, still between pixels
// Notes: data turns over once its hold time ends
`timescale 1ns/1ps
module prpi_src
(
   output logic o_clk,
   output logic [29:0] o_data,
   output logic o_fs,
   output logic o_ls,
   output logic o_dv
);
   // Idle at time zero
   initial
   begin
      o_clk = 0;
      {o_data, o_fs, o_ls, o_dv} = 0;
   end
   // One 48 ns period; every change sits at least half a ns off the sys rising edges
   task automatic send(logic [29:0] d, logic v, logic f, logic l);
      #0.5;
      {o_data, o_dv, o_fs, o_ls} = {d, v, f, l};
      #24 o_clk = 1;
      #23 o_clk = 0;
      o_data = ~o_data;
      #0.5;
   endtask
endmodule // prpi_src

// >>> tb/prpi_top_tb_top.sv
// Purpose: self-checking bench for prpi_top
// Assumes: one source per pixel clock
// Notes: queues hold the expected words
`timescale 1ns/1ps
`include "prpi_consts.vh"
`define CHK(g, e) begin checks++; if ((g) !== (e)) begin err_total++; \
   $display("unexpected t=%0t got %h exp %h", $time, g, e); end end
module prpi_top_tb_top;
   logic clk, rst_n, u3, ovr, r1, r2;
   logic [5:0] sw [2];
   logic [5:0] tab [6] = '{6'h24, 6'h06, 6'h18, 6'h21, 6'h09, 6'h3f};
   logic [1:0] pf = 0, pl = 0, mf = 0, ml = 0;
   logic [25:0] q1 [$], q2 [$], x1, x2;
   int err_total, checks;
   wire [29:0] d1, d2, d3;
   wire [23:0] o1, o2;
   wire c1, c2, c3, f1, f2, f3, l1, l2, l3, v1, v2, v3;
   wire vd1, vd2, fs1, fs2, ls1, ls2, or1, or2;
   prpi_src i_s1 (.o_clk(c1), .o_data(d1), .o_fs(f1), .o_ls(l1), .o_dv(v1));
   prpi_src i_s2 (.o_clk(c2), .o_data(d2), .o_fs(f2), .o_ls(l2), .o_dv(v2));
   prpi_src i_s3 (.o_clk(c3), .o_data(d3), .o_fs(f3), .o_ls(l3), .o_dv(v3));
   prpi_top i_dut (.i_clk_sys(clk), .i_rst_n(rst_n),
      .i_port_one_pixel_clock(c1), .i_port_two_pixel_clock(c2),
      .i_optional_third_pixel_clock(c3), .i_port_one_use_third_clock(1'b0),
      .i_port_two_use_third_clock(u3),
      .i_port_one_colour_data({d1[29:22], d1[19:12], d1[9:2]}),
      .i_port_two_colour_data(u3 ? d3 : d2),
      .i_port_one_frame_sync(f1), .i_port_one_line_sync(l1),
      .i_port_one_data_valid(v1), .i_port_two_frame_sync(u3 ? f3 : f2),
      .i_port_two_line_sync(u3 ? l3 : l2),
      .i_port_two_data_valid(u3 ? v3 : v2),
      .i_port_one_swap(sw[0]), .i_port_two_swap(sw[1]),
      .i_port_one_ready(r1), .i_port_two_ready(r2),
      .o_port_one_pixel(o1), .o_port_one_valid(vd1),
      .o_port_one_frame_start(fs1), .o_port_one_line_start(ls1),
      .o_port_one_overrun(or1), .o_port_two_pixel(o2),
      .o_port_two_valid(vd2), .o_port_two_frame_start(fs2),
      .o_port_two_line_start(ls2), .o_port_two_overrun(or2));
   // System clock, 5 ns
   initial
   begin
      clk = 0;
      forever #2.5 clk = ~clk;
   end
   // Random consumer stalls
   always @(posedge clk)
   begin
      #1;
      r1 = ovr ? 1'b0 : 1'($urandom);
      r2 = 1'($urandom);
   end
   // Taken words against the model, looked at mid-cycle
   always @(negedge clk)
   begin
      if (vd1 === 1'b1 && r1 === 1'b1)
      begin
         x1 = q1.pop_front();
         `CHK({fs1, ls1, o1}, x1)
      end
      if (vd2 === 1'b1 && r2 === 1'b1)
      begin
         x2 = q2.pop_front();
         `CHK({fs2, ls2, o2}, x2)
      end
   end
   function automatic logic [7:0] pk(logic [29:0] d, logic [1:0] k);
      return (k == `PRPI_SEL_B) ? d[19:12] :
         (k == `PRPI_SEL_C) ? d[29:22] : d[9:2];
   endfunction
   function automatic logic [23:0] remap(logic [29:0] d, logic [5:0] s);
      return {pk(d, s[1:0]), pk(d, s[3:2]), pk(d, s[5:4])};
   endfunction
   // One pixel period through source p, model alongside
   task automatic px(int p, logic v, logic f, logic l);
      int k;
      logic [29:0] d;
      k = (p == 1) ? 0 : 1;
      d = 30'($urandom);
      mf[k] = mf[k] | (f & ~pf[k]);
      ml[k] = ml[k] | (l & ~pl[k]);
      pf[k] = f;
      pl[k] = l;
      // A dropped word leaves its marks pending for the next one
      if (v && (k == 1 || !ovr || q1.size() < 2))
      begin
         if (k == 1)
            q2.push_back({mf[k], ml[k], remap(d, sw[k])});
         else
            q1.push_back({mf[k], ml[k], remap(d, sw[k])});
         mf[k] = 0;
         ml[k] = 0;
      end
      case (p)
         1: i_s1.send(d, v, f, l);
         2: i_s2.send(d, v, f, l);
         default: i_s3.send(d, v, f, l);
      endcase
   endtask
   // Idle, frame and line sync, n pixels, new line, one pixel
   task automatic frame(int p, int n);
      px(p, 0, 0, 0);
      px(p, 0, 1, 1);
      repeat (n) px(p, 1, 0, 0);
      px(p, 0, 0, 1);
      px(p, 1, 0, 0);
   endtask
   // Wait, bounded, until all expected words are taken
   task automatic drain;
      int n;
      n = 0;
      while (q1.size() + q2.size() > 0 && n < 400)
      begin
         @(posedge clk);
         n++;
      end
      `CHK(q1.size() + q2.size(), 0)
      @(posedge clk);
      #1;
   endtask
   task automatic wrap_up;
      $display("checks %0d errors %0d", checks, err_total);
      if (err_total == 0 && checks > 0)
         $display("TB: PASS");
      else
         $display("TB: FAIL");
      $finish;
   endtask
   // Main sequence
   initial
   begin
      {rst_n, u3, ovr, r1, r2} = 0;
      sw[0] = `PRPI_SWAP_RST;
      sw[1] = `PRPI_SWAP_RST;
      void'($urandom(3245));
      repeat (4) @(posedge clk);
      #1 rst_n = 1;
      repeat (3) @(posedge clk);
      #1;
      foreach (tab[i])
      begin
         sw[0] = tab[i];
         sw[1] = tab[5 - i];
         frame(1, 4);
         frame(2, 4);
         drain;
      end
      u3 = 1;
      frame(3, 4);
      drain;
      u3 = 0;
      ovr = 1;
      frame(1, 2);
      repeat (10) @(posedge clk);
      `CHK(or1, 1'b1)
      #1 ovr = 0;
      drain;
      `CHK(or2, 1'b0)
      wrap_up;
   end
   // Watchdog
   initial
   begin
      #200000;
      err_total++;
      wrap_up;
   end
endmodule // prpi_top_tb_top
